// file: design/instruction_sequencer.sv
//
// Contract
// RQ1 - opcode is instruction bits 0-2; 0-5 reference memory, 6-7 do not
// RQ2 - memory-reference work takes whole memory cycles; indirect adds one cycle
// RQ3 - io transfer takes a 4.25 us stretched cycle, operate one 1.6 us cycle
// RQ4 - pages of 128 words, 32 per field; bits 5-11 give the page offset
// RQ5 - bit 4 set picks the current page, clear picks page zero
// RQ6 - bit 3 set reads the page word and uses it as absolute address
// RQ7 - opcode 0 ands operand into working register, operand restored
// RQ8 - opcode 1 adds operand; carry out flips carry bit; operand restored
// RQ9 - opcode 2 increments operand, writes it back, skips next when zero
// RQ10 - opcode 3 stores working register into operand, then clears it
// RQ11 - opcode 4 stores return pointer at Y, continues at Y plus one
// RQ12 - opcode 5 loads operand address into the instruction pointer
// RQ13 - opcodes 6 and 7 run in the first cycle without operand cycle
// RQ14 - opcode 6 sets the stretch flag and starts strobes chosen by bits 9-11
// RQ15 - strobes one microsecond apart; bit 11 at time 1, bit 10 at time 2
// RQ16 - peripherals gate processor strobes into their own device strobes
// RQ17 - a peripheral answers only when bits 3-8 match its selector code
// RQ18 - bit 9 gates the third strobe; an unset strobe still spends its slot
// RQ19 - instruction pointer steps by one after each fetch before any skip or jump
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "sequencer_defines.svh"

module instruction_sequencer (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_run,
   input wire logic i_load_pointer,
   input wire logic [11:0] i_load_value,
   input wire logic [11:0] i_mem_rdata,
   output logic [11:0] o_mem_address,
   output logic o_mem_read,
   output logic o_mem_write,
   output logic [11:0] o_mem_wdata,
   output logic [11:0] o_instruction_pointer,
   output logic [11:0] o_working_register,
   output logic o_carry_bit,
   output logic [2:0] o_opcode_holder,
   output sequencer_pkg::state_type o_cycle_state,
   output logic o_stretch_flag,
   output logic [5:0] o_device_code,
   output logic [2:0] o_io_strobe_source
);
   import sequencer_pkg::*;

   // next word in twelve-bit two's complement
   function automatic word_type next_word(input word_type value);
      next_word = value + `WORD_ONE;
   endfunction : next_word

   // page-relative address from an instruction and the pointer it came from
   function automatic word_type page_address(input word_type instr, input word_type where);
      logic [4:0] page;
      page = instr[`CURRENT_PAGE_BIT] ? where[`PAGE_MSB:`PAGE_LSB] : `PAGE_ZERO; // RQ5
      page_address = {page, instr[`OFFSET_MSB:0]}; // RQ4
   endfunction : page_address

   state_type state_q, state_d;
   word_type pointer_q, pointer_d;
   word_type working_q, working_d;
   logic carry_q, carry_d;
   word_type instr_q, instr_d;
   opcode_type opcode_q, opcode_d;
   word_type operand_q, operand_d;
   logic stretch_q, stretch_d;
   logic [5:0] device_q, device_d;
   word_type address_q, address_d;
   logic read_q, read_d;
   logic write_q, write_d;
   word_type wdata_q, wdata_d;

   logic cycle_begin;
   logic cycle_take;
   logic cycle_finish;
   logic strobe_start;
   logic [2:0] strobe_pulses;
   logic [12:0] sum;
   word_type bumped;
   word_type fetched_y;
   opcode_type fetched_op;

   // memory cycle phases; the stretch flag lengthens the first cycle
   cycle_timer timer (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_enable(state_q != idle_state),
      .i_stretch(stretch_q),
      .o_begin(cycle_begin),
      .o_take(cycle_take),
      .o_finish(cycle_finish)
   );

   // timed strobes for the peripheral selectors
   io_strobe_generator strobes (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_start(strobe_start),
      .i_select(instr_d[`IO_SELECT_MSB:0]),
      .o_strobe(strobe_pulses)
   );

   // decode of the word arriving in a first cycle
   always_comb begin
      fetched_op = opcode_type'(i_mem_rdata[`OPCODE_MSB:`OPCODE_LSB]); // RQ1
      fetched_y = page_address(i_mem_rdata, pointer_q);
      sum = {1'b0, working_q} + {1'b0, i_mem_rdata};
      bumped = next_word(i_mem_rdata);
      strobe_start = cycle_take && (state_q == first_cycle_state) && (fetched_op == io_transfer_op); // RQ14
   end

   // memory strobes: read at the cycle start, write back at its end
   always_comb begin
      address_d = address_q;
      read_d = 1'b0;
      write_d = 1'b0;
      if (cycle_begin) begin
         read_d = 1'b1;
         unique case (state_q)
            first_cycle_state: address_d = pointer_q;
            defer_state: address_d = page_address(instr_q, address_q); // RQ6
            operand_cycle_state: address_d = operand_q;
            idle_state: address_d = address_q;
         endcase
      end
      if (cycle_finish) begin
         write_d = 1'b1;
      end
   end

   // sequencing and execution of each cycle
   always_comb begin
      state_d = state_q;
      pointer_d = pointer_q;
      working_d = working_q;
      carry_d = carry_q;
      instr_d = instr_q;
      opcode_d = opcode_q;
      operand_d = operand_q;
      stretch_d = stretch_q;
      device_d = device_q;
      wdata_d = wdata_q;
      unique case (state_q)
         idle_state: begin
            if (i_load_pointer) begin
               pointer_d = i_load_value;
            end
            if (i_run) begin
               state_d = first_cycle_state;
            end
         end
         first_cycle_state: begin
            if (cycle_take) begin
               instr_d = i_mem_rdata;
               opcode_d = fetched_op; // RQ1
               operand_d = fetched_y; // RQ5
               wdata_d = i_mem_rdata;
               pointer_d = next_word(pointer_q); // RQ19
               if (fetched_op == jump_op && !i_mem_rdata[`INDIRECT_BIT]) begin
                  pointer_d = fetched_y; // RQ12
               end
               if (fetched_op == io_transfer_op) begin
                  stretch_d = 1'b1; // RQ14
                  device_d = i_mem_rdata[`DEVICE_MSB:`DEVICE_LSB];
               end
            end
            if (cycle_finish) begin
               stretch_d = 1'b0;
               unique case (opcode_q)
                  logical_mask_op, add_op, increment_skip_zero_op, store_clear_op, subroutine_call_op: begin
                     state_d = instr_q[`INDIRECT_BIT] ? defer_state : operand_cycle_state; // RQ2
                  end
                  jump_op: begin
                     state_d = instr_q[`INDIRECT_BIT] ? defer_state : first_cycle_state; // RQ12
                  end
                  io_transfer_op, operate_op: begin
                     state_d = first_cycle_state; // RQ13
                  end
               endcase
            end
         end
         defer_state: begin
            if (cycle_take) begin
               operand_d = i_mem_rdata; // RQ6
               wdata_d = i_mem_rdata;
               if (opcode_q == jump_op) begin
                  pointer_d = i_mem_rdata; // RQ12
               end
            end
            if (cycle_finish) begin
               state_d = (opcode_q == jump_op) ? first_cycle_state : operand_cycle_state; // RQ2
            end
         end
         operand_cycle_state: begin
            if (cycle_take) begin
               wdata_d = i_mem_rdata;
               unique case (opcode_q)
                  logical_mask_op: begin
                     working_d = working_q & i_mem_rdata; // RQ7
                  end
                  add_op: begin
                     working_d = sum[11:0]; // RQ8
                     carry_d = carry_q ^ sum[12]; // RQ8
                  end
                  increment_skip_zero_op: begin
                     wdata_d = bumped; // RQ9
                     if (bumped == `WORD_ZERO) begin
                        pointer_d = next_word(pointer_q); // RQ9
                     end
                  end
                  store_clear_op: begin
                     wdata_d = working_q; // RQ10
                     working_d = `WORD_ZERO; // RQ10
                  end
                  subroutine_call_op: begin
                     wdata_d = pointer_q; // RQ11
                     pointer_d = next_word(operand_q); // RQ11
                  end
                  jump_op, io_transfer_op, operate_op: begin
                     wdata_d = i_mem_rdata;
                  end
               endcase
            end
            if (cycle_finish) begin
               state_d = first_cycle_state;
            end
         end
      endcase
      // a dropped run request stops at the end of the current cycle
      if (cycle_finish && !i_run) begin
         state_d = idle_state;
      end
   end

   // state and data registers
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         state_q <= idle_state;
         pointer_q <= `WORD_ZERO;
         working_q <= `WORD_ZERO;
         carry_q <= 1'b0;
         instr_q <= `WORD_ZERO;
         opcode_q <= logical_mask_op;
         operand_q <= `WORD_ZERO;
         stretch_q <= 1'b0;
         device_q <= 6'h00;
         wdata_q <= `WORD_ZERO;
      end else begin
         state_q <= state_d;
         pointer_q <= pointer_d;
         working_q <= working_d;
         carry_q <= carry_d;
         instr_q <= instr_d;
         opcode_q <= opcode_d;
         operand_q <= operand_d;
         stretch_q <= stretch_d;
         device_q <= device_d;
         wdata_q <= wdata_d;
      end
   end

   // memory strobe registers
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         address_q <= `WORD_ZERO;
         read_q <= 1'b0;
         write_q <= 1'b0;
      end else begin
         address_q <= address_d;
         read_q <= read_d;
         write_q <= write_d;
      end
   end

   // outputs, all from flip-flops
   always_comb begin
      o_mem_address = address_q;
      o_mem_read = read_q;
      o_mem_write = write_q;
      o_mem_wdata = wdata_q;
      o_instruction_pointer = pointer_q;
      o_working_register = working_q;
      o_carry_bit = carry_q;
      o_opcode_holder = opcode_q;
      o_cycle_state = state_q;
      o_stretch_flag = stretch_q;
      o_device_code = device_q;
      o_io_strobe_source = strobe_pulses; // RQ16 RQ17
   end
endmodule : instruction_sequencer
`default_nettype wire

// file: pkg/sequencer_defines.svh
`ifndef SEQUENCER_DEFINES_SVH
`define SEQUENCER_DEFINES_SVH

// clock and documented times, in ns
`define CLOCK_PERIOD_NS 25
`define MEM_CYCLE_NS 1600
`define STRETCH_CYCLE_NS 4250
`define STROBE_SPACING_NS 1000

// derived clock counts, least times rounded up
`define MEM_CYCLE_CLOCKS ((`MEM_CYCLE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define STRETCH_CYCLE_CLOCKS ((`STRETCH_CYCLE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define STROBE_SPACING_CLOCKS ((`STROBE_SPACING_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

// phases inside one memory cycle
`define PHASE_BEGIN 8'h00
`define PHASE_TAKE 8'h02

// instruction fields, bit 0 of the documented word is the msb here
`define OPCODE_MSB 11
`define OPCODE_LSB 9
`define INDIRECT_BIT 8
`define CURRENT_PAGE_BIT 7
`define OFFSET_MSB 6
`define PAGE_MSB 11
`define PAGE_LSB 7
`define DEVICE_MSB 8
`define DEVICE_LSB 3
`define IO_SELECT_MSB 2

// widths and reset values
`define WORD_ZERO 12'h000
`define WORD_ONE 12'h001
`define PAGE_ZERO 5'h00
`define NUM_STROBES 3
`define LAST_EVENT 2'h3

`endif

// file: pkg/sequencer_pkg.sv
package sequencer_pkg;

   typedef logic [11:0] word_type;

   // gray along idle -> first -> defer -> operand
   typedef enum logic [1:0] {
      idle_state = 2'b00,
      first_cycle_state = 2'b01,
      defer_state = 2'b11,
      operand_cycle_state = 2'b10
   } state_type;

   typedef enum logic [2:0] {
      logical_mask_op = 3'h0,
      add_op = 3'h1,
      increment_skip_zero_op = 3'h2,
      store_clear_op = 3'h3,
      subroutine_call_op = 3'h4,
      jump_op = 3'h5,
      io_transfer_op = 3'h6,
      operate_op = 3'h7
   } opcode_type;

endpackage : sequencer_pkg

// file: design/cycle_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "sequencer_defines.svh"

module cycle_timer (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_enable,
   input wire logic i_stretch,
   output logic o_begin,
   output logic o_take,
   output logic o_finish
);
   localparam logic [7:0] normal_last = 8'(`MEM_CYCLE_CLOCKS - 1);
   localparam logic [7:0] stretch_last = 8'(`STRETCH_CYCLE_CLOCKS - 1);

   logic [7:0] count_q;
   logic [7:0] count_d;
   logic [7:0] last;

   // phase decode of the running cycle
   always_comb begin
      last = i_stretch ? stretch_last : normal_last; // RQ3
      o_begin = i_enable && (count_q == `PHASE_BEGIN);
      o_take = i_enable && (count_q == `PHASE_TAKE);
      o_finish = i_enable && (count_q == last); // RQ2
   end

   // next count, wraps at the end of each cycle
   always_comb begin
      if (!i_enable || count_q == last) begin
         count_d = `PHASE_BEGIN;
      end else begin
         count_d = count_q + 8'h01;
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         count_q <= 8'h00;
      end else begin
         count_q <= count_d;
      end
   end
endmodule : cycle_timer
`default_nettype wire

// file: design/io_strobe_generator.sv
`timescale 1ns/1ps
`default_nettype none
`include "sequencer_defines.svh"

module io_strobe_generator (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_start,
   input wire logic [2:0] i_select,
   output logic [2:0] o_strobe
);
   localparam logic [5:0] spacing_last = 6'(`STROBE_SPACING_CLOCKS - 1);

   logic active_q, active_d;
   logic [5:0] tick_q, tick_d;
   logic [1:0] event_q, event_d;
   logic [2:0] select_q, select_d;
   logic [2:0] strobe_d;

   // event times 1, 2, 3 fall one spacing apart after the start
   always_comb begin
      active_d = active_q;
      tick_d = tick_q;
      event_d = event_q;
      select_d = select_q;
      strobe_d = 3'h0;
      if (i_start) begin
         active_d = 1'b1;
         tick_d = 6'h00;
         event_d = 2'h0;
         select_d = i_select; // RQ14
      end else if (active_q) begin
         if (tick_q == spacing_last) begin // RQ15
            tick_d = 6'h00;
            event_d = event_q + 2'h1;
            // a cleared bit still lets its slot elapse
            strobe_d[event_q] = select_q[event_q]; // RQ15 RQ18
            if (event_q + 2'h1 == `LAST_EVENT) begin
               active_d = 1'b0;
            end
         end else begin
            tick_d = tick_q + 6'h01;
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         active_q <= 1'b0;
         tick_q <= 6'h00;
         event_q <= 2'h0;
         select_q <= 3'h0;
         o_strobe <= 3'h0;
      end else begin
         active_q <= active_d;
         tick_q <= tick_d;
         event_q <= event_d;
         select_q <= select_d;
         o_strobe <= strobe_d;
      end
   end
endmodule : io_strobe_generator
`default_nettype wire

// file: bench/instruction_sequencer_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module sequencer_monitor (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic [11:0] i_mem_rdata,
   input wire logic [11:0] o_mem_address,
   input wire logic o_mem_read,
   input wire logic [11:0] o_instruction_pointer,
   input wire logic [2:0] o_opcode_holder,
   input wire sequencer_pkg::state_type o_cycle_state,
   input wire logic o_stretch_flag,
   input wire logic [2:0] o_io_strobe_source
);
   import sequencer_pkg::*;
   logic [7:0] gap_q;
   logic [7:0] gap_d;
   logic [7:0] hold_q;
   logic [7:0] hold_d;
   logic seen_q;
   logic seen_d;
   logic fetch;

   // clocks since the last read, and since the stretch flag rose
   assign fetch = o_mem_read && (o_cycle_state == first_cycle_state);
   always_comb begin
      gap_d = o_mem_read ? 8'h01 : ((gap_q == 8'hff) ? gap_q : gap_q + 8'h01);
      hold_d = o_stretch_flag ? hold_q + 8'h01 : 8'h00;
      seen_d = o_mem_read || (seen_q && (o_cycle_state != idle_state));
   end
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         gap_q <= 8'h00;
         hold_q <= 8'h00;
         seen_q <= 1'b0;
      end else begin
         gap_q <= gap_d;
         hold_q <= hold_d;
         seen_q <= seen_d;
      end
   end

   default clocking @(posedge i_clock); endclocking
   default disable iff (i_reset);

   property p_cycle_len;
      o_mem_read && seen_q |-> (gap_q == 8'h40) || (gap_q == 8'haa && o_opcode_holder == io_transfer_op);
   endproperty
   a_cycle_len: assert property (p_cycle_len) else $error("memory cycle length wrong");
   property p_opcode_take;
      fetch |-> ##3 ({o_opcode_holder, 9'h000} == ($past(i_mem_rdata, 2) & 12'he00));
   endproperty
   a_opcode_take: assert property (p_opcode_take) else $error("opcode not taken from top bits");
   // a direct jump replaces the stepped pointer in the same cycle
   property p_pointer_step;
      fetch |-> ##3 (((o_opcode_holder == jump_op) && !$past(i_mem_rdata[8], 2)) ?
         (o_instruction_pointer == {($past(i_mem_rdata[7], 2) ? o_mem_address[11:7] : 5'h00),
         $past(i_mem_rdata[6:0], 2)}) : (o_instruction_pointer == o_mem_address + 12'h001));
   endproperty
   a_pointer_step: assert property (p_pointer_step) else $error("pointer did not step after fetch");
   property p_aug_no_operand;
      o_mem_read && !fetch |-> o_opcode_holder <= 3'h5;
   endproperty
   a_aug_no_operand: assert property (p_aug_no_operand) else $error("augmented op read memory");
   property p_jump_single;
      o_cycle_state == operand_cycle_state |-> o_opcode_holder != jump_op;
   endproperty
   a_jump_single: assert property (p_jump_single) else $error("jump used an operand cycle");
   property p_strobe_io;
      |o_io_strobe_source |-> o_stretch_flag && o_opcode_holder == io_transfer_op;
   endproperty
   a_strobe_io: assert property (p_strobe_io) else $error("strobe outside io cycle");
   property p_strobe_one;
      o_io_strobe_source[0] |-> hold_q inside {[8'h27:8'h2a]};
   endproperty
   a_strobe_one: assert property (p_strobe_one) else $error("first strobe mistimed");
   property p_strobe_two;
      o_io_strobe_source[1] |-> hold_q inside {[8'h4f:8'h52]};
   endproperty
   a_strobe_two: assert property (p_strobe_two) else $error("second strobe mistimed");
   property p_strobe_three;
      o_io_strobe_source[2] |-> hold_q inside {[8'h77:8'h7a]};
   endproperty
   a_strobe_three: assert property (p_strobe_three) else $error("third strobe mistimed");
   property p_stretch_len;
      $fell(o_stretch_flag) |-> $past(hold_q) inside {[8'ha3:8'ha8]};
   endproperty
   a_stretch_len: assert property (p_stretch_len) else $error("stretch length wrong");

   c_defer: cover property (o_cycle_state == defer_state);
   c_third: cover property (o_io_strobe_source[2]);
   c_stretch: cover property ($fell(o_stretch_flag));
endmodule : sequencer_monitor

bind instruction_sequencer sequencer_monitor i_monitor (.i_clock, .i_reset, .i_mem_rdata, .o_mem_address,
   .o_mem_read, .o_instruction_pointer, .o_opcode_holder, .o_cycle_state, .o_stretch_flag, .o_io_strobe_source);

`default_nettype wire

// file: bench/core_partner.sv
`timescale 1ns/1ps
`default_nettype none

module core_partner #(
   parameter logic [5:0] select_code = 6'h2a
) (
   input wire logic i_clock,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [11:0] i_address,
   input wire logic [11:0] i_wdata,
   output logic [11:0] o_rdata,
   input wire logic [2:0] i_strobe,
   input wire logic [5:0] i_device_code,
   output logic [2:0] o_device_strobe
);
   logic [11:0] mem [0:4095];

   // word valid only in the cycle after a read, scrambled otherwise
   initial o_rdata = 12'h000;
   always @(posedge i_clock) begin
      if (i_read) begin
         o_rdata <= mem[i_address];
      end else begin
         o_rdata <= ~o_rdata;
      end
      if (i_write) begin
         mem[i_address] <= i_wdata;
      end
   end

   // selector passes strobes only when the device code matches
   assign o_device_strobe = (i_device_code == select_code) ? i_strobe : 3'h0;
endmodule : core_partner

`default_nettype wire

// file: bench/twelve_bit_instruction_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module twelve_bit_instruction_sequencer_tb;
   import sequencer_pkg::*;
   logic i_clock, i_reset, i_run, i_load_pointer, o_mem_read, o_mem_write, o_carry_bit, o_stretch_flag;
   logic [11:0] i_load_value, i_mem_rdata, o_mem_address, o_mem_wdata, o_instruction_pointer, o_working_register;
   logic [2:0] o_opcode_holder, o_io_strobe_source, device_strobe;
   logic [5:0] o_device_code;
   state_type o_cycle_state;
   int failures, check_count, io_count[3], dev_count[3];
   logic [11:0] fetch_tab[12] = '{12'h080, 12'h081, 12'h082, 12'h083, 12'h084, 12'h086,
      12'h0c1, 12'h0c2, 12'h0c3, 12'h0c4, 12'h0c5, 12'h0c5};
   logic [11:0] clock_tab[11] = '{12'h080, 12'h080, 12'h0c0, 12'h080, 12'h080, 12'h080,
      12'h0aa, 12'h0aa, 12'h040, 12'h080, 12'h040};
   logic [11:0] prog_a[7] = '{12'h210, 12'h011, 12'h3a0, 12'h612, 12'h413, 12'h210, 12'h8c0};
   logic [11:0] prog_b[5] = '{12'hd55, 12'hcaa, 12'he00, 12'hb14, 12'hac5};

   instruction_sequencer i_dut (.i_clock, .i_reset, .i_run, .i_load_pointer, .i_load_value, .i_mem_rdata,
      .o_mem_address, .o_mem_read, .o_mem_write, .o_mem_wdata, .o_instruction_pointer, .o_working_register,
      .o_carry_bit, .o_opcode_holder, .o_cycle_state, .o_stretch_flag, .o_device_code, .o_io_strobe_source);
   core_partner i_mem (.i_clock(i_clock), .i_read(o_mem_read), .i_write(o_mem_write), .i_address(o_mem_address),
      .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata), .i_strobe(o_io_strobe_source),
      .i_device_code(o_device_code), .o_device_strobe(device_strobe));

   initial begin
      i_clock = 1'b0;
      forever #12.5 i_clock = ~i_clock;
   end

   // tally processor strobes and the selected device's strobes
   always @(posedge i_clock) begin
      for (int k = 0; k < 3; k++) begin
         io_count[k] += int'(o_io_strobe_source[k] === 1'b1);
         dev_count[k] += int'(device_strobe[k] === 1'b1);
      end
   end

   task automatic check12(input logic [11:0] got, input logic [11:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : check12

   task automatic finish_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test

   // wait for the next instruction fetch read, counting falling edges
   task automatic wait_fetch(output int n);
      n = 0;
      while (!(o_mem_read === 1'b1 && o_cycle_state === first_cycle_state)) begin
         @(negedge i_clock);
         n++;
         if (n > 400) begin
            failures++;
            $display("[FAIL] %0t no fetch seen", $time);
            finish_test();
         end
      end
   endtask : wait_fetch

   // program at two places in page one, data in page zero and beyond
   task automatic load_program();
      foreach (prog_a[k]) i_mem.mem[12'h080 + k] = prog_a[k];
      foreach (prog_b[k]) i_mem.mem[12'h0c1 + k] = prog_b[k];
      i_mem.mem[12'h010] = 12'hfff;
      i_mem.mem[12'h011] = 12'h0f3;
      i_mem.mem[12'h012] = 12'h555;
      i_mem.mem[12'h013] = 12'hfff;
      i_mem.mem[12'h014] = 12'h0c5;
      i_mem.mem[12'h0a0] = 12'h300;
      i_mem.mem[12'h300] = 12'hfff;
   endtask : load_program

   // load pointer in idle, start, then try a load that must be ignored
   task automatic start_run();
      @(posedge i_clock);
      i_load_pointer <= 1'b1;
      i_load_value <= 12'h080;
      @(posedge i_clock);
      i_load_pointer <= 1'b0;
      i_run <= 1'b1;
      @(posedge i_clock);
      i_load_pointer <= 1'b1;
      i_load_value <= 12'h000;
      @(posedge i_clock);
      i_load_pointer <= 1'b0;
   endtask : start_run

   // follow each fetch address and the clocks each instruction takes
   task automatic step_program();
      int n;
      @(negedge i_clock);
      wait_fetch(n);
      for (int k = 0; k < 11; k++) begin
         check12(o_mem_address, fetch_tab[k], "fetch address");
         @(negedge i_clock);
         wait_fetch(n);
         check12(12'(n + 1), clock_tab[k], "instruction clocks");
      end
      check12(o_mem_address, fetch_tab[11], "fetch address");
   endtask : step_program

   // stop at a cycle end, then judge registers, memory and strobes
   task automatic stop_and_check();
      @(posedge i_clock);
      i_run <= 1'b0;
      for (int n = 0; n < 300 && o_cycle_state !== idle_state; n++) @(negedge i_clock);
      check12(12'(o_cycle_state), 12'(idle_state), "stop state");
      check12(o_working_register, 12'h000, "working register");
      check12({11'h000, o_carry_bit}, 12'h001, "carry");
      check12(i_mem.mem[12'h012], 12'h0f2, "stored word");
      check12(i_mem.mem[12'h013], 12'h000, "incremented word");
      check12(i_mem.mem[12'h0c0], 12'h087, "return address");
      check12(i_mem.mem[12'h010], 12'hfff, "restored operand");
      check12(i_mem.mem[12'h011], 12'h0f3, "restored mask");
      check12(i_mem.mem[12'h0a0], 12'h300, "restored pointer word");
      for (int k = 0; k < 3; k++) begin
         check12(12'(io_count[k]), 12'h001, "processor strobes");
      end
      check12(12'(dev_count[0]), 12'h001, "device strobe one");
      check12(12'(dev_count[1]), 12'h000, "device strobe two");
      check12(12'(dev_count[2]), 12'h001, "device strobe three");
   endtask : stop_and_check

   // reset in mid-run clears everything at once, then a fresh start runs again
   task automatic reset_mid_run();
      int n;
      @(posedge i_clock);
      i_run <= 1'b1;
      repeat (100) @(posedge i_clock);
      i_reset <= 1'b1;
      i_run <= 1'b0;
      @(negedge i_clock);
      check12(o_instruction_pointer, 12'h000, "pointer after reset");
      check12({9'h000, o_opcode_holder}, 12'h000, "opcode after reset");
      check12({10'h000, o_cycle_state}, 12'h000, "state after reset");
      check12({9'h000, o_io_strobe_source}, 12'h000, "strobes after reset");
      check12({10'h000, o_mem_read, o_stretch_flag}, 12'h000, "controls after reset");
      repeat (4) @(posedge i_clock);
      i_reset <= 1'b0;
      repeat (2) @(negedge i_clock);
      check12({10'h000, o_cycle_state}, 12'h000, "idle after release");
      start_run();
      @(negedge i_clock);
      wait_fetch(n);
      check12(o_mem_address, 12'h080, "fetch after reset");
   endtask : reset_mid_run

   initial begin
      i_reset = 1'b1;
      i_run = 1'b0;
      i_load_pointer = 1'b0;
      i_load_value = 12'h000;
      load_program();
      repeat (4) @(posedge i_clock);
      i_reset <= 1'b0;
      start_run();
      step_program();
      stop_and_check();
      reset_mid_run();
      finish_test();
   end
endmodule : twelve_bit_instruction_sequencer_tb

`default_nettype wire
